// ---- verilog/pmgc_top.sv ----
// pll miscellaneous control and general-purpose clock selectors behind an avalon-mm slave
// Operation
// - strap override makes input type, frequency, divider table come from register
// - buffer supply select: 0 internal regulator, 1 external supply
// - bias current select: 0 internal, 1 external
// - lock force reports pll locked regardless of lock detector
// - power-good check active at 0, check module disabled at 1
// - output frequency bit 1 uses internal table, ignores pins; 0 register frequencies
// - divider table bit uses internal divider table, only under strap override
// - force-on powers up all divider chains, else mode-select table
// - input type 0 cml, 1 cmos, only under override, else 0
// - pll mode decode: test, app a, app b, app one, phy, wireless
// - gp selector: 101 quarter system clock, 110 crystal output, 111 divided 250 MHz
// - second gp selector register with identical layout at its own offset
// - 250 MHz path divided by 2*(divider+1) before the output
module pmgc_top
	import pmgc_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [15:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic xo_clk_in,
	input wire logic two_fifty_mhz_clock_in,
	input wire logic pll_lock_detect_in,
	input wire logic [1:0] crystal_strap_in,
	input wire logic divider_table_strap_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output pmgc_pll_cfg_t pll_cfg_out,
	output logic pll_locked_out,
	output logic [1:0] gp_clock_out
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] misc_reg;
	logic [15:0] gpc_reg [2];
	logic [15:0] sysdiv_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	pmgc_strap_t strap_reg;
	logic strap_taken_reg;
	logic [1:0] strap_settle_reg;
	logic [1:0] strap_sync1_reg;
	logic [1:0] strap_sync2_reg;
	logic dts_sync1_reg;
	logic dts_sync2_reg;
	logic lock_sync1_reg;
	logic lock_sync2_reg;
	logic xo_sync1_reg;
	logic xo_sync2_reg;
	logic c250_sync1_reg;
	logic c250_sync2_reg;
	logic c250_prev_reg;
	logic [1:0] quarter_reg;
	logic [8:0] div_cnt_reg [2];
	logic [1:0] div_clk_reg;
	pmgc_pll_cfg_t cfg_next;
	logic req;

	// byte-lane merge shared by all writable registers
	function automatic logic [15:0] pmgc_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
		begin
			r[7:0] = wd[7:0];
		end
		if (be[1])
		begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// divided 250 MHz terminal count: half period is divider+1 sampled edges
	function automatic logic [8:0] pmgc_half(input logic [15:0] d);
		return {1'b0, d[7:0]};
	endfunction

	assign req = avs_read_in | avs_write_in;

	// ----------------------------------------
	// avalon slave: one wait cycle, then ack
	// ----------------------------------------
	// waitrequest is high until the ack cycle so the master holds its request
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ack_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= req & ~ack_reg;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			avs_waitrequest_out <= 1'b1;
		end
		else
		begin
			avs_waitrequest_out <= ~(req & ~ack_reg);
		end
	end

	// register writes land at the ack edge only
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			misc_reg <= PMGC_MISC_RESET;
			gpc_reg[0] <= PMGC_GPC_RESET;
			gpc_reg[1] <= PMGC_GPC_RESET;
			sysdiv_reg <= PMGC_SYSDIV_RESET;
		end
		else if (avs_write_in && ack_reg)
		begin
			case (avs_address_in)
				PMGC_MISC_ADDR: misc_reg <= pmgc_merge(misc_reg, avs_writedata_in,
					avs_byteenable_in) & 16'h9fff; // bits 14:13 not held here
				PMGC_GPC0_ADDR: gpc_reg[0] <= pmgc_merge(gpc_reg[0], avs_writedata_in,
					avs_byteenable_in) & 16'h0007;
				PMGC_GPC1_ADDR: gpc_reg[1] <= pmgc_merge(gpc_reg[1], avs_writedata_in,
					avs_byteenable_in) & 16'h0007;
				PMGC_SYSDIV_ADDR: sysdiv_reg <= pmgc_merge(sysdiv_reg, avs_writedata_in,
					avs_byteenable_in) & 16'h00ff;
				default: ;
			endcase
		end
	end

	// read data is prepared in the wait cycle and stands with the ack
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rdata_reg <= 32'h0000_0000;
		end
		else if (avs_read_in && !ack_reg)
		begin
			case (avs_address_in)
				PMGC_MISC_ADDR: rdata_reg <= {16'h0000, misc_reg};
				PMGC_GPC0_ADDR: rdata_reg <= {16'h0000, gpc_reg[0]};
				PMGC_GPC1_ADDR: rdata_reg <= {16'h0000, gpc_reg[1]};
				PMGC_SYSDIV_ADDR: rdata_reg <= {16'h0000, sysdiv_reg};
				default: rdata_reg <= 32'h0000_0000; // unmapped reads as zero
			endcase
		end
	end
	assign avs_readdata_out = rdata_reg;

	// ----------------------------------------
	// pin synchronisers and strap capture
	// ----------------------------------------
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			strap_sync1_reg <= 2'h0;
			strap_sync2_reg <= 2'h0;
			dts_sync1_reg <= 1'b0;
			dts_sync2_reg <= 1'b0;
			lock_sync1_reg <= 1'b0;
			lock_sync2_reg <= 1'b0;
		end
		else
		begin
			strap_sync1_reg <= crystal_strap_in;
			strap_sync2_reg <= strap_sync1_reg;
			dts_sync1_reg <= divider_table_strap_in;
			dts_sync2_reg <= dts_sync1_reg;
			lock_sync1_reg <= pll_lock_detect_in;
			lock_sync2_reg <= lock_sync1_reg;
		end
	end

	// clock pins are sampled as data through their own two stages; the gp
	// outputs only follow them at this clock's resolution
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			xo_sync1_reg <= 1'b0;
			xo_sync2_reg <= 1'b0;
			c250_sync1_reg <= 1'b0;
			c250_sync2_reg <= 1'b0;
		end
		else
		begin
			xo_sync1_reg <= xo_clk_in;
			xo_sync2_reg <= xo_sync1_reg;
			c250_sync1_reg <= two_fifty_mhz_clock_in;
			c250_sync2_reg <= c250_sync1_reg;
		end
	end

	// straps are caught once, after both synchroniser stages hold pin values;
	// capturing earlier would latch the synchronisers' reset zeros instead
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			strap_reg <= '0;
			strap_taken_reg <= 1'b0;
			strap_settle_reg <= 2'h0;
		end
		else if (!strap_taken_reg)
		begin
			if (strap_settle_reg == 2'(PMGC_STRAP_SETTLE))
			begin
				strap_reg <= {strap_sync2_reg, dts_sync2_reg};
				strap_taken_reg <= 1'b1;
			end
			else
			begin
				strap_settle_reg <= strap_settle_reg + 2'h1;
			end
		end
	end

	// ----------------------------------------
	// effective pll configuration
	// ----------------------------------------
	always_comb
	begin
		cfg_next = '0;
		cfg_next.buffer_supply_external = misc_reg[PMGC_BUFFER_SUPPLY_EXTERNAL_BIT];
		cfg_next.bias_current_external = misc_reg[PMGC_BIAS_BIT];
		cfg_next.power_good_check_override = misc_reg[PMGC_POK_BIT];
		cfg_next.output_freq_table_select = misc_reg[PMGC_OFREQ_BIT];
		cfg_next.use_pin_freq_select = 1'b0;
		cfg_next.divider_chain_force_on = misc_reg[PMGC_FORCEON_BIT];
		cfg_next.pll_operating_mode = misc_reg[PMGC_MODE_LSB +: 3];
		if (misc_reg[PMGC_STRAP_OVR_BIT])
		begin
			cfg_next.divider_table_select = misc_reg[PMGC_DIVTAB_BIT];
			cfg_next.ref_frequency_select = pmgc_ref_t'(misc_reg[PMGC_REFSEL_LSB +: 2]);
			cfg_next.input_is_cmos = misc_reg[PMGC_INTYPE_BIT];
		end
		else
		begin
			cfg_next.divider_table_select = strap_reg.divider_table_strap;
			cfg_next.ref_frequency_select = pmgc_ref_t'(strap_reg.crystal_strap);
			cfg_next.input_is_cmos = 1'b0;
		end
		// one-hot mode decode; undocumented codes leave all flags low
		case (pmgc_mode_t'(misc_reg[PMGC_MODE_LSB +: 3]))
			PMGC_MODE_TEST: cfg_next.mode_flags = 6'h01;
			PMGC_MODE_APP_A: cfg_next.mode_flags = 6'h02;
			PMGC_MODE_APP_B: cfg_next.mode_flags = 6'h04;
			PMGC_MODE_APP_ONE: cfg_next.mode_flags = 6'h08;
			PMGC_MODE_PHY: cfg_next.mode_flags = 6'h10;
			PMGC_MODE_WIRELESS: cfg_next.mode_flags = 6'h20;
			default: cfg_next.mode_flags = 6'h00;
		endcase
	end

	// configuration and lock status are registered toward the macro
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pll_cfg_out <= '0;
			pll_locked_out <= 1'b0;
		end
		else
		begin
			pll_cfg_out <= cfg_next;
			pll_locked_out <= misc_reg[PMGC_LOCK_BIT] | lock_sync2_reg;
		end
	end

	// ----------------------------------------
	// general-purpose clock generation
	// ----------------------------------------
	// quarter system clock: 2-bit counter, top bit is a 25 percent-rate square
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			quarter_reg <= 2'h0;
			c250_prev_reg <= 1'b0;
		end
		else
		begin
			quarter_reg <= quarter_reg + 2'h1;
			c250_prev_reg <= c250_sync2_reg;
		end
	end

	// 250 MHz rising edges counted as sampled; a fast source aliases at this clock,
	// so the divided output is only exact when the source is slower than half clock_in
	for (genvar g = 0; g < 2; g++)
	begin : gen_div
		always_ff @(posedge clock_in or posedge rst_in)
		begin
			if (rst_in)
			begin
				div_cnt_reg[g] <= 9'h000;
				div_clk_reg[g] <= 1'b0;
			end
			else if (c250_sync2_reg && !c250_prev_reg)
			begin
				if (div_cnt_reg[g] >= pmgc_half(sysdiv_reg))
				begin
					div_cnt_reg[g] <= 9'h000;
					div_clk_reg[g] <= ~div_clk_reg[g];
				end
				else
				begin
					div_cnt_reg[g] <= div_cnt_reg[g] + 9'h001;
				end
			end
		end

		// output mux, registered so every output leaves a flip-flop
		always_ff @(posedge clock_in or posedge rst_in)
		begin
			if (rst_in)
			begin
				gp_clock_out[g] <= 1'b0;
			end
			else
			begin
				case (gpc_reg[g][2:0])
					PMGC_SRC_QUARTER: gp_clock_out[g] <= quarter_reg[1];
					PMGC_SRC_XO: gp_clock_out[g] <= xo_sync2_reg;
					PMGC_SRC_250: gp_clock_out[g] <= div_clk_reg[g];
					default: gp_clock_out[g] <= 1'b0;
				endcase
			end
		end
	end
endmodule // pmgc_top

// ---- verilog/pmgc_pkg.sv ----
// package: register map, field positions and reset values of the pll misc / gp clock block
package pmgc_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [15:0] PMGC_GPC0_ADDR = 16'hf948;
	localparam logic [15:0] PMGC_GPC1_ADDR = 16'hf94c;
	localparam logic [15:0] PMGC_MISC_ADDR = 16'hf940;
	localparam logic [15:0] PMGC_SYSDIV_ADDR = 16'hf950;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] PMGC_GPC_RESET = 16'h0007;
	localparam logic [15:0] PMGC_MISC_RESET = 16'h0022;
	localparam logic [15:0] PMGC_SYSDIV_RESET = 16'h0000;
	// clock edges after reset release before the strap synchronisers hold pin values
	localparam int PMGC_STRAP_SETTLE = 2;
	// ----------------------------------------
	// misc control field positions
	// ----------------------------------------
	localparam int PMGC_STRAP_OVR_BIT = 15;
	localparam int PMGC_BUFFER_SUPPLY_EXTERNAL_BIT = 12;
	localparam int PMGC_BIAS_BIT = 11;
	localparam int PMGC_LOCK_BIT = 10;
	localparam int PMGC_POK_BIT = 9;
	localparam int PMGC_OFREQ_BIT = 8;
	localparam int PMGC_DIVTAB_BIT = 7;
	localparam int PMGC_FORCEON_BIT = 6;
	localparam int PMGC_REFSEL_LSB = 4;
	localparam int PMGC_INTYPE_BIT = 3;
	localparam int PMGC_MODE_LSB = 0;
	// ----------------------------------------
	// enumerations
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		PMGC_SRC_QUARTER = 3'h5,
		PMGC_SRC_XO = 3'h6,
		PMGC_SRC_250 = 3'h7
	} pmgc_src_t;
	typedef enum logic [2:0]
	{
		PMGC_MODE_TEST = 3'h0,
		PMGC_MODE_APP_A = 3'h1,
		PMGC_MODE_APP_B = 3'h2,
		PMGC_MODE_APP_ONE = 3'h3,
		PMGC_MODE_PHY = 3'h4,
		PMGC_MODE_WIRELESS = 3'h5
	} pmgc_mode_t;
	typedef enum logic [1:0]
	{
		PMGC_REF_36 = 2'h0,
		PMGC_REF_40 = 2'h1,
		PMGC_REF_25 = 2'h2,
		PMGC_REF_125 = 2'h3
	} pmgc_ref_t;
	// effective pll configuration handed to the analog macro
	typedef struct packed
	{
		logic buffer_supply_external;
		logic bias_current_external;
		logic power_good_check_override;
		logic output_freq_table_select;
		logic use_pin_freq_select;
		logic divider_table_select;
		logic divider_chain_force_on;
		pmgc_ref_t ref_frequency_select;
		logic input_is_cmos;
		logic [2:0] pll_operating_mode;
		logic [5:0] mode_flags;
	} pmgc_pll_cfg_t;
	// strap pins captured once, on the third clock edge after reset release
	typedef struct packed
	{
		logic [1:0] crystal_strap;
		logic divider_table_strap;
	} pmgc_strap_t;
endpackage : pmgc_pkg

// ---- sim/pmgc_assertions.sv ----
// checker: bus handshake, config routing and gp output properties
module pmgc_checker
	import pmgc_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [15:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic pll_lock_detect_in,
	input wire logic avs_waitrequest_out,
	input wire pmgc_pll_cfg_t pll_cfg_out,
	input wire logic pll_locked_out,
	input wire logic [1:0] gp_clock_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// helpers
	// ----
	logic wr_ack;
	logic [2:0] sel0_reg;
	assign wr_ack = avs_write_in && !avs_waitrequest_out;
	// shadow of selector 0, so output checks know the code in force
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			sel0_reg <= 3'h7;
		else if (wr_ack && avs_address_in == PMGC_GPC0_ADDR && avs_byteenable_in[0])
			sel0_reg <= avs_writedata_in[2:0];
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// full-word misc write accepted at this edge
	sequence misc_wr;
		wr_ack && avs_address_in == PMGC_MISC_ADDR && avs_byteenable_in == 4'h3;
	endsequence
	// ----
	// properties
	// ----
	a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("request not acked after one wait");
	a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("ack held over one cycle");
	a_lock_force: assert property (misc_wr ##0 avs_writedata_in[10] |-> ##2 pll_locked_out)
		else $error("lock force ignored");
	a_lock_det: assert property (pll_lock_detect_in [*4] |=> pll_locked_out)
		else $error("detected lock not reported");
	a_cfg_fields: assert property (misc_wr |-> ##2 {pll_cfg_out.buffer_supply_external,
		pll_cfg_out.bias_current_external, pll_cfg_out.power_good_check_override,
		pll_cfg_out.output_freq_table_select, pll_cfg_out.divider_chain_force_on}
		== $past({avs_writedata_in[12:11], avs_writedata_in[9:8], avs_writedata_in[6]}, 2))
		else $error("misc bits not routed");
	a_cfg_mode: assert property (misc_wr |-> ##2 pll_cfg_out.pll_operating_mode
		== $past(avs_writedata_in[2:0], 2)) else $error("mode field not routed");
	a_mode_flags: assert property (!$past(rst_in) |-> pll_cfg_out.mode_flags ==
		((pll_cfg_out.pll_operating_mode < 3'h6) ? 6'h1 << pll_cfg_out.pll_operating_mode
		: 6'h0)) else $error("mode decode wrong");
	a_cmos_ovr: assert property (misc_wr |-> ##2 pll_cfg_out.input_is_cmos
		== $past(avs_writedata_in[15] && avs_writedata_in[3], 2)) else $error("input type wrong");
	a_ovr_fields: assert property (misc_wr ##0 avs_writedata_in[15] |-> ##2
		{pll_cfg_out.ref_frequency_select, pll_cfg_out.divider_table_select}
		== $past({avs_writedata_in[5:4], avs_writedata_in[7]}, 2)) else $error("override lost");
	a_gp_low: assert property ((sel0_reg < 3'h5) [*4] |-> !gp_clock_out[0])
		else $error("reserved code drives output");
	a_quarter_rate: assert property ((sel0_reg == 3'h5) [*8] |-> gp_clock_out[0]
		!= $past(gp_clock_out[0], 2)) else $error("quarter clock rate wrong");
endmodule // pmgc_checker

// ---- sim/pll_misc_and_gp_clock_select_tb.sv ----
// testbench: registers, pll config and gp clock outputs
module pll_misc_and_gp_clock_select_tb
	import pmgc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [15:0] avs_address_in = 16'h0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [3:0] avs_byteenable_in = 4'h3;
	logic [31:0] avs_writedata_in = 32'h0;
	logic xo_clk_in = 1'b0;
	logic two_fifty_mhz_clock_in = 1'b0;
	logic pll_lock_detect_in = 1'b0;
	logic [1:0] crystal_strap_in = 2'h2;
	logic divider_table_strap_in = 1'b1;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	pmgc_pll_cfg_t pll_cfg_out;
	logic pll_locked_out;
	logic [1:0] gp_clock_out;
	int failures = 0;
	int compares = 0;
	logic [15:0] q;
	logic [15:0] model_reg[4];
	localparam logic [15:0] reg_addr[4] = '{PMGC_MISC_ADDR, PMGC_GPC0_ADDR, PMGC_GPC1_ADDR,
		PMGC_SYSDIV_ADDR};
	localparam logic [15:0] reg_mask[4] = '{16'h9fff, 16'h0007, 16'h0007, 16'h00ff};
	localparam logic [15:0] reg_rst[4] = '{PMGC_MISC_RESET, PMGC_GPC_RESET, PMGC_GPC_RESET,
		PMGC_SYSDIV_RESET};
	pmgc_top dut_u (.clock_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_byteenable_in, .avs_writedata_in, .xo_clk_in, .two_fifty_mhz_clock_in, .pll_lock_detect_in,
		.crystal_strap_in, .divider_table_strap_in, .avs_readdata_out, .avs_waitrequest_out,
		.pll_cfg_out, .pll_locked_out, .gp_clock_out);
	// clocks; pin clocks are offset so their edges never meet the system edge
	initial forever #12.5 clock_in = ~clock_in;
	initial #7 forever #40 xo_clk_in = ~xo_clk_in;
	initial #3 forever #100 two_fifty_mhz_clock_in = ~two_fifty_mhz_clock_in;
	// ----
	// tasks
	// ----
	task automatic summarize;
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer; holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
		int n = 0;
		avs_address_in <= a;
		avs_writedata_in <= {16'h0, d};
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do
		begin
			@(posedge clock_in);
			n++;
		end
		while (avs_waitrequest_out !== 1'b0 && n < 64);
		if (avs_waitrequest_out !== 1'b0)
		begin
			failures++;
			$display("CHECK FAILED %0t no ack", $time);
			summarize();
		end
		else
		begin
			q = avs_readdata_out[15:0];
			avs_write_in <= 1'b0;
			avs_read_in <= 1'b0;
			@(posedge clock_in);
		end
	endtask
	// expected pll config from a misc register value and the straps
	function automatic pmgc_pll_cfg_t exp_cfg(input logic [15:0] v);
		exp_cfg = '0;
		exp_cfg.buffer_supply_external = v[12];
		exp_cfg.bias_current_external = v[11];
		exp_cfg.power_good_check_override = v[9];
		exp_cfg.output_freq_table_select = v[8];
		exp_cfg.divider_table_select = v[15] ? v[7] : divider_table_strap_in;
		exp_cfg.divider_chain_force_on = v[6];
		exp_cfg.ref_frequency_select = pmgc_ref_t'(v[15] ? v[5:4] : crystal_strap_in);
		exp_cfg.input_is_cmos = v[15] & v[3];
		exp_cfg.pll_operating_mode = v[2:0];
		exp_cfg.mode_flags = (v[2:0] < 3'h6) ? 6'h1 << v[2:0] : 6'h0;
	endfunction
	// gp edges in a 2400 ns window; reserved codes also count any high sample
	function automatic int exp_tr(input int s, input int d);
		return s < 5 ? 0 : s == 5 ? 48 : s == 6 ? 60 : 12 / (d + 1);
	endfunction
	// ----
	// main sequence
	// ----
	initial
	begin
		int n, i, d, s, b, e;
		int c[2];
		logic [1:0] p;
		logic [15:0] v;
		logic [15:0] m;
		for (i = 0; i < 4; i++)
			model_reg[i] = reg_rst[i];
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		void'($urandom(20));
		@(posedge clock_in);
		for (i = 0; i < 5; i++)
		begin
			bus(1'b0, i < 4 ? reg_addr[i] : 16'hf944, 16'h0);
			check(q, i < 4 ? reg_rst[i] : 16'h0);
		end
		check(32'(pll_cfg_out), 32'(exp_cfg(reg_rst[0])));
		// random writes everywhere, unmapped included, with the detector flipping
		for (n = 0; n < 20; n++)
		begin
			i = n % 5;
			v = 16'($urandom);
			// first misc write forces override, lock force and cmos; the second clears override and lock force
			if (n == 0)
				v = v | 16'h8408;
			if (n == 5)
				v = v & 16'h7bff;
			// full-word writes first, then random byte lanes
			b = (n < 10) ? 3 : int'($urandom % 4);
			m = {{8{b[1]}}, {8{b[0]}}};
			pll_lock_detect_in <= 1'($urandom);
			avs_byteenable_in <= 4'(b);
			bus(1'b1, i < 4 ? reg_addr[i] : 16'hf944, v);
			if (i < 4)
				model_reg[i] = ((model_reg[i] & ~m) | (v & m)) & reg_mask[i];
			bus(1'b0, i < 4 ? reg_addr[i] : 16'hf944, 16'h0);
			check(q, i < 4 ? model_reg[i] : 16'h0);
			repeat (4) @(posedge clock_in);
			check(32'(pll_cfg_out), 32'(exp_cfg(model_reg[0])));
			check(pll_locked_out, model_reg[0][10] | pll_lock_detect_in);
		end
		avs_byteenable_in <= 4'h3;
		// every selector code on both outputs, divider varied
		for (s = 0; s < 8; s++)
		begin
			d = $urandom % 3;
			bus(1'b1, PMGC_SYSDIV_ADDR, 16'(d));
			bus(1'b1, PMGC_GPC0_ADDR, 16'(s));
			bus(1'b1, PMGC_GPC1_ADDR, 16'(7 - s));
			// walk every mode code too, strap path in force
			bus(1'b1, PMGC_MISC_ADDR, 16'(s));
			repeat (8) @(posedge clock_in);
			check(32'(pll_cfg_out), 32'(exp_cfg(16'(s))));
			c = '{0, 0};
			p = gp_clock_out;
			repeat (96)
			begin
				@(posedge clock_in);
				for (b = 0; b < 2; b++)
					c[b] += int'(gp_clock_out[b] !== p[b]) +
						int'((b ? 7 - s : s) < 5 && gp_clock_out[b] !== 1'b0);
				p = gp_clock_out;
			end
			for (b = 0; b < 2; b++)
			begin
				e = exp_tr(b ? 7 - s : s, d);
				check(32'(c[b] <= e + 1 && c[b] + 1 >= e), 32'h1);
			end
		end
		summarize();
	end
endmodule // pll_misc_and_gp_clock_select_tb
bind pmgc_top pmgc_checker chk_u (.clock_in, .rst_in, .avs_address_in, .avs_read_in,
	.avs_write_in, .avs_byteenable_in, .avs_writedata_in, .pll_lock_detect_in,
	.avs_waitrequest_out, .pll_cfg_out, .pll_locked_out, .gp_clock_out);
